// ===== i2c_rp_pkg.sv
// shared constants and types of the serial read-pointer slave
`default_nettype none
package i2c_rp_pkg;
   localparam logic [6:0]  RTC_SLAVE       = 7'h68;    // 1101000
   localparam logic [3:0]  MEM_SMALL_TOP   = 4'ha;     // 1010xxx
   localparam logic [6:0]  MEM_LARGE_SLAVE = 7'h50;    // 1010000
   localparam logic [7:0]  RTC_LAST        = 8'hff;    // last clock location
   localparam logic [12:0] MEM_SMALL_MASK  = 13'h07ff;
   localparam logic [12:0] MEM_LARGE_MASK  = 13'h1fff;
   localparam logic [12:0] PTR_RESET       = 13'h0000;
   localparam logic [7:0]  IDLE_BYTE       = 8'hff;    // sent on underrun
   localparam int          BYTE_W          = 8;
   localparam int          FIFO_DEPTH      = 4;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK_WAIT, ST_ACK, ST_RX, ST_TX, ST_MACK
   } link_state_t;
endpackage
`default_nettype wire

// ===== fifo_buf.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module fifo_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             clr,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   // depth must be a power of two: pointers wrap by width
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } fifo_state_t;

   fifo_state_t q;
   fifo_state_t n;
   logic        do_w;
   logic        do_r;

   // handshake flags straight from the count
   assign in_ready  = (q.cnt != FULL);
   assign out_valid = (q.cnt != '0);
   assign out_data  = q.mem[q.rp];
   assign do_w      = in_valid & in_ready;
   assign do_r      = out_valid & out_ready;

   // next state; clear wins over both sides
   always_comb begin
      n = q;
      if (clr) begin
         n.wp  = '0;
         n.rp  = '0;
         n.cnt = '0;
      end else begin
         if (do_w) begin
            n.mem[q.wp] = in_data;
            n.wp        = q.wp + 1'b1;
         end
         if (do_r)
            n.rp = q.rp + 1'b1;
         if (do_w && !do_r)
            n.cnt = q.cnt + 1'b1;
         else if (do_r && !do_w)
            n.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         q <= '0;
      else
         q <= n;
   end
endmodule
`default_nettype wire

// ===== i2c_read_pointer.sv
// serial-bus slave: address match, pointer keeping, byte streaming
// Operation
// R1 - direction bit one selects slave transmit
// R2 - matched address byte gets low acknowledge
// R3 - send bytes msb first from pointer
// R4 - pointer kept across transfers without write
// R5 - stream while acked; release after not-ack
// R6 - address-only write sets read start
// R7 - pointer advances by one per byte
// R8 - clock set answers address 1101000
// R9 - small memory: 1010 plus block bits
// R10 - large memory: 1010000, two address bytes
// R11 - pointer wraps to zero past end
`timescale 1ns/100ps
`default_nettype none
module i2c_read_pointer #(
   parameter bit MEM_LARGE = 1'b0
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        link_clk,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   output logic             acc_mem,
   output logic [12:0]      acc_addr,
   output logic             acc_rd,
   output logic             acc_wr,
   output logic [7:0]       acc_wdata,
   input  wire logic [7:0]  acc_rdata
);
   typedef struct packed {
      logic                     scl_m, scl_s, scl_p;
      logic                     sda_m, sda_s, sda_p;
      logic                     ack_m, ack_s;
      i2c_rp_pkg::link_state_t  st;
      logic [2:0]               cnt;
      logic [7:0]               sh;
      logic                     oe, seen, rw, sel, rd_act, pend;
      logic                     req_t, r_we, r_mem, epoch, r_ep;
      logic [1:0]               rx_num;
      logic [7:0]               rtc_ptr;
      logic [12:0]              mem_ptr, f_ptr, r_addr;
      logic [7:0]               r_wd;
   } link_t;

   typedef struct packed {
      logic        rq_m, rq_s, rq_p, rd, wr, cap, ack_t, mem;
      logic [12:0] addr;
      logic [7:0]  wd, rdata;
   } sys_t;

   link_t       q, n;
   sys_t        s_q, s_n;
   logic        rise, fall, start, stop, busy, m_rtc, m_mem, match;
   logic        push, pop, clr, tx_load, f_ready, f_valid;
   logic [7:0]  f_data, tx_byte, rx_byte;
   logic [12:0] cur, rtc_nxt;
   logic [6:0]  slave;

   function automatic logic [12:0] adv(input logic mem,
                                       input logic [12:0] p);
      if (mem)
         adv = (p + 13'h0001) & (MEM_LARGE ? i2c_rp_pkg::MEM_LARGE_MASK
                                           : i2c_rp_pkg::MEM_SMALL_MASK);
      else if (p[7:0] == i2c_rp_pkg::RTC_LAST)
         adv = 13'h0000;
      else
         adv = {5'h00, p[7:0] + 8'h01};
   endfunction

   // bus events from the second and third sampling stages only
   assign rise  = q.scl_s & ~q.scl_p;
   assign fall  = ~q.scl_s & q.scl_p;
   assign start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
   assign stop  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
   assign busy  = q.req_t != q.ack_s;
   assign slave = q.sh[6:0];
   assign m_rtc = slave == i2c_rp_pkg::RTC_SLAVE;                     // R8
   assign m_mem = MEM_LARGE ? slave == i2c_rp_pkg::MEM_LARGE_SLAVE    // R10
                            : slave[6:3] == i2c_rp_pkg::MEM_SMALL_TOP; // R9
   assign match = m_rtc | m_mem;
   assign cur   = q.sel ? q.mem_ptr : {5'h00, q.rtc_ptr};
   // clock set step; a call result cannot be part-selected directly
   assign rtc_nxt = adv(1'b0, cur);
   assign rx_byte = {q.sh[6:0], q.sda_s};
   assign tx_byte = f_valid ? f_data : i2c_rp_pkg::IDLE_BYTE;
   // a byte is loaded on the falling edge closing an ack slot
   assign tx_load = fall & q.seen & q.rw & ~start & ~stop
                  & ((q.st == i2c_rp_pkg::ST_ACK) | (q.st == i2c_rp_pkg::ST_MACK));
   assign pop   = tx_load & f_valid;
   // stale answers from an ended read are dropped by epoch
   assign push  = q.pend & ~busy & ~q.r_we & (q.r_ep == q.epoch) & q.rd_act;
   assign clr   = (start | stop) & q.rd_act
                | (q.st == i2c_rp_pkg::ST_MACK & rise & q.sda_s);
   assign sda_o  = 1'b0;
   assign sda_oe = q.oe;

   // link side: sampling, prefetch and bit engine
   always_comb begin
      n = q;
      n.scl_m = scl_i;
      n.scl_s = q.scl_m;
      n.scl_p = q.scl_s;
      n.sda_m = sda_i;
      n.sda_s = q.sda_m;
      n.sda_p = q.sda_s;
      n.ack_m = s_q.ack_t;
      n.ack_s = q.ack_m;
      if (q.pend && !busy)
         n.pend = 1'b0;
      // prefetch; fifo ready holds it back when the buffer is full
      if (q.rd_act && !q.pend && f_ready && !clr) begin
         n.req_t = ~q.req_t;
         n.pend  = 1'b1;
         n.r_we  = 1'b0;
         n.r_mem = q.sel;
         n.r_addr = q.f_ptr;
         n.r_ep  = q.epoch;
         n.f_ptr = adv(q.sel, q.f_ptr);                               // R11
      end
      if (clr) begin
         n.rd_act = 1'b0;
         n.epoch  = ~q.epoch;
      end
      if (start) begin
         n.st  = i2c_rp_pkg::ST_ADDR;
         n.cnt = 3'h0;
         n.oe  = 1'b0;
      end else if (stop) begin
         n.st = i2c_rp_pkg::ST_IDLE;
         n.oe = 1'b0;
      end else begin
         case (q.st)
            i2c_rp_pkg::ST_ADDR: begin
               if (rise) begin
                  n.sh  = rx_byte;
                  n.cnt = q.cnt + 3'h1;
                  if (q.cnt == 3'h7) begin
                     n.st     = match ? i2c_rp_pkg::ST_ACK_WAIT
                                      : i2c_rp_pkg::ST_IDLE;
                     n.rw     = q.sda_s;                              // R1
                     n.sel    = m_mem;
                     n.rx_num = 2'h0;
                     if (m_mem && !MEM_LARGE)
                        n.mem_ptr[10:8] = slave[2:0];                 // R9
                     if (match && q.sda_s) begin
                        n.rd_act = 1'b1;                              // R1
                        n.f_ptr  = m_mem ? (MEM_LARGE ? q.mem_ptr
                                   : {2'b00, slave[2:0], q.mem_ptr[7:0]})
                                   : {5'h00, q.rtc_ptr};              // R4
                     end
                  end
               end
            end
            i2c_rp_pkg::ST_ACK_WAIT: begin
               if (fall) begin
                  n.oe   = 1'b1;                                      // R2
                  n.seen = 1'b0;
                  n.st   = i2c_rp_pkg::ST_ACK;
               end
            end
            i2c_rp_pkg::ST_ACK: begin
               if (rise)
                  n.seen = 1'b1;
               if (fall && q.seen) begin
                  n.oe  = 1'b0;
                  n.cnt = 3'h0;
                  n.st  = q.rw ? i2c_rp_pkg::ST_TX : i2c_rp_pkg::ST_RX;
               end
            end
            i2c_rp_pkg::ST_RX: begin
               if (rise) begin
                  n.sh  = rx_byte;
                  n.cnt = q.cnt + 3'h1;
                  if (q.cnt == 3'h7) begin
                     n.st = i2c_rp_pkg::ST_ACK_WAIT;
                     if (q.rx_num == 2'h0) begin                      // R6
                        n.rx_num = 2'h1;
                        if (q.sel && MEM_LARGE)
                           n.mem_ptr[12:8] = rx_byte[4:0];            // R10
                        else if (q.sel)
                           n.mem_ptr[7:0] = rx_byte;
                        else
                           n.rtc_ptr = rx_byte;
                     end else if (q.rx_num == 2'h1 && q.sel && MEM_LARGE) begin
                        n.rx_num       = 2'h2;
                        n.mem_ptr[7:0] = rx_byte;                     // R10
                     end else begin
                        // a byte arriving with a write still open is lost
                        if (!q.pend) begin
                           n.req_t  = ~q.req_t;
                           n.pend   = 1'b1;
                           n.r_we   = 1'b1;
                           n.r_mem  = q.sel;
                           n.r_addr = cur;
                           n.r_wd   = rx_byte;
                        end
                        if (q.sel)
                           n.mem_ptr = adv(1'b1, q.mem_ptr);          // R7
                        else
                           n.rtc_ptr = rtc_nxt[7:0];                  // R7
                     end
                  end
               end
            end
            i2c_rp_pkg::ST_TX: begin
               if (fall) begin
                  n.cnt = q.cnt + 3'h1;
                  if (q.cnt == 3'h7) begin
                     n.oe   = 1'b0;
                     n.seen = 1'b0;
                     n.st   = i2c_rp_pkg::ST_MACK;
                  end else begin
                     n.sh = {q.sh[6:0], 1'b0};
                     n.oe = ~q.sh[6];                                 // R3
                  end
               end
            end
            i2c_rp_pkg::ST_MACK: begin
               if (rise) begin
                  if (q.sda_s)
                     n.st = i2c_rp_pkg::ST_IDLE;                      // R5
                  else
                     n.seen = 1'b1;
               end
            end
            default: n.st = i2c_rp_pkg::ST_IDLE;
         endcase
      end
      // shared byte load after an ack slot
      if (tx_load) begin
         n.sh  = tx_byte;
         n.oe  = ~tx_byte[7];                                         // R3
         n.cnt = 3'h0;
         n.st  = i2c_rp_pkg::ST_TX;                                   // R5
         if (q.sel)
            n.mem_ptr = adv(1'b1, q.mem_ptr);                         // R7
         else
            n.rtc_ptr = rtc_nxt[7:0];                                 // R11
      end
   end

   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         q         <= '0;
         q.scl_m   <= 1'b1;
         q.scl_s   <= 1'b1;
         q.scl_p   <= 1'b1;
         q.sda_m   <= 1'b1;
         q.sda_s   <= 1'b1;
         q.sda_p   <= 1'b1;
         q.st      <= i2c_rp_pkg::ST_IDLE;
         q.mem_ptr <= i2c_rp_pkg::PTR_RESET;
      end else begin
         q <= n;
      end
   end

   fifo_buf #(
      .WIDTH (i2c_rp_pkg::BYTE_W),
      .DEPTH (i2c_rp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (link_clk),
      .rst       (rst),
      .clr       (clr),
      .in_valid  (push),
      .in_ready  (f_ready),
      .in_data   (s_q.rdata),
      .out_valid (f_valid),
      .out_ready (tx_load),
      .out_data  (f_data)
   );

   // system side: toggle handshake; request fields held by the link side
   always_comb begin
      s_n      = s_q;
      s_n.rq_m = q.req_t;
      s_n.rq_s = s_q.rq_m;
      s_n.rd   = 1'b0;
      s_n.wr   = 1'b0;
      s_n.cap  = s_q.rd;
      if (s_q.rq_s != s_q.rq_p) begin
         s_n.rq_p = s_q.rq_s;
         s_n.mem  = q.r_mem;
         s_n.addr = q.r_addr;
         s_n.wd   = q.r_wd;
         s_n.rd   = ~q.r_we;
         s_n.wr   = q.r_we;
      end
      if (s_q.wr)
         s_n.ack_t = ~s_q.ack_t;
      if (s_q.cap) begin
         s_n.rdata = acc_rdata;
         s_n.ack_t = ~s_q.ack_t;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_n;
   end

   assign acc_mem   = s_q.mem;
   assign acc_addr  = s_q.addr;
   assign acc_rd    = s_q.rd;
   assign acc_wr    = s_q.wr;
   assign acc_wdata = s_q.wd;

   // checks on the link side
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (rst);
   property p_read_sel;
      q.st == i2c_rp_pkg::ST_ADDR && rise && q.cnt == 3'h7 && match
         && q.sda_s && !start && !stop |=> q.rd_act && q.rw;
   endproperty
   a_read_sel: assert property (p_read_sel) else $error("read not selected"); // R1
   property p_ack_low;
      q.st == i2c_rp_pkg::ST_ACK_WAIT && fall && !start && !stop
         |=> q.oe && q.st == i2c_rp_pkg::ST_ACK;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("no address ack"); // R2
   property p_msb;
      tx_load |=> q.oe == ~$past(tx_byte[7]) && q.cnt == 3'h0;
   endproperty
   a_msb: assert property (p_msb) else $error("msb not driven first"); // R3
   property p_keep;
      q.st == i2c_rp_pkg::ST_IDLE |=> $stable(q.rtc_ptr);
   endproperty
   a_keep: assert property (p_keep) else $error("pointer moved idle"); // R4
   property p_nack;
      q.st == i2c_rp_pkg::ST_MACK && rise && q.sda_s && !start && !stop
         |=> !q.oe && q.st == i2c_rp_pkg::ST_IDLE && !q.rd_act;
   endproperty
   a_nack: assert property (p_nack) else $error("no release on nack"); // R5
   property p_incr;
      tx_load && !q.sel |=> q.rtc_ptr == 8'($past(q.rtc_ptr) + 8'h01);
   endproperty
   a_incr: assert property (p_incr) else $error("pointer not advanced"); // R7
   property p_rtc_addr;
      q.st == i2c_rp_pkg::ST_ADDR && rise && q.cnt == 3'h7
         && q.sh[6:0] == i2c_rp_pkg::RTC_SLAVE && !start && !stop
         |=> q.st == i2c_rp_pkg::ST_ACK_WAIT ##[1:300] q.oe;
   endproperty
   a_rtc_addr: assert property (p_rtc_addr) else $error("clock addr missed"); // R8
   property p_wrap;
      tx_load && !q.sel && q.rtc_ptr == i2c_rp_pkg::RTC_LAST
         |=> q.rtc_ptr == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // R11
   property p_rx_quiet;
      q.st == i2c_rp_pkg::ST_RX |-> !q.oe;
   endproperty
   a_rx_quiet: assert property (p_rx_quiet) else $error("drive in receive"); // R6
   c_read:  cover property (tx_load ##[1:1000] q.st == i2c_rp_pkg::ST_MACK);
   c_nack:  cover property (q.st == i2c_rp_pkg::ST_MACK && rise && q.sda_s);
   c_ptr:   cover property (q.st == i2c_rp_pkg::ST_RX && rise
                            && q.cnt == 3'h7 && q.rx_num == 2'h0);
   c_full:  cover property (!f_ready && q.rd_act);
endmodule
`default_nettype wire

// ===== i2c_master_model.sv
// bus master model driving the clock and data lines
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model #(
   parameter int Q = 80
) (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   // both lines idle high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // start condition, also usable as repeated start
   task automatic start_cond();
      sda_low = 1'b0;
      #(Q) scl = 1'b1;
      #(2*Q) sda_low = 1'b1;
      #(2*Q) scl = 1'b0;
   endtask
   // data low under a low clock, then rises while clock high
   task automatic stop_cond();
      #(Q) sda_low = 1'b1;
      #(Q) scl = 1'b1;
      #(2*Q) sda_low = 1'b0;
      #(2*Q);
   endtask
   // data changes only mid low phase, sampled mid high phase
   task automatic clock_bit(input logic b, output logic s);
      #(Q) sda_low = ~b;
      #(Q) scl = 1'b1;
      #(Q) s = sda;
      #(Q) scl = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
      clock_bit(1'b1, ack);
   endtask
   // last byte answered with not-ack so the slave lets go
   task automatic recv_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
      clock_bit(last, s);
   endtask
endmodule
`default_nettype wire

// ===== i2c_slave_read_pointer_tb.sv
// self-checking bench of the serial read-pointer slave
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_read_pointer_tb;
   logic        clk, rst, link_clk, scl, m_low;
   logic        sda_o, sda_oe, acc_mem, acc_rd, acc_wr;
   logic [12:0] acc_addr, rtc_ptr, mem_ptr;
   logic [7:0]  acc_wdata, acc_rdata;
   logic [7:0]  rtc_mem [0:255];
   logic [7:0]  fm_mem [0:8191];
   wire  logic  sda_bus;
   // second bus carrying the large memory variant
   logic        scl_l, m_low_l, sda_o_l, sda_oe_l, acc_mem_l, acc_rd_l;
   logic [12:0] acc_addr_l;
   logic [7:0]  acc_rdata_l;
   wire  logic  sda_bus_l;
   integer      seed = 32'h554624cd;
   int          bad_count, comparisons, cycles;

   // wired-and data line, pull-up when nobody pulls
   assign sda_bus = (m_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

   i2c_master_model #(.Q(80)) u_master (
      .scl(scl), .sda_low(m_low), .sda(sda_bus));

   i2c_read_pointer #(.MEM_LARGE(1'b0)) u_dut (
      .clk(clk), .rst(rst), .link_clk(link_clk), .scl_i(scl),
      .sda_i(sda_bus), .sda_o(sda_o), .sda_oe(sda_oe),
      .acc_mem(acc_mem), .acc_addr(acc_addr), .acc_rd(acc_rd),
      .acc_wr(acc_wr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata));

   assign sda_bus_l = (m_low_l | (sda_oe_l & ~sda_o_l)) ? 1'b0 : 1'b1;

   i2c_master_model #(.Q(80)) u_master_l (
      .scl(scl_l), .sda_low(m_low_l), .sda(sda_bus_l));

   i2c_read_pointer #(.MEM_LARGE(1'b1)) u_dut_l (
      .clk(clk), .rst(rst), .link_clk(link_clk), .scl_i(scl_l),
      .sda_i(sda_bus_l), .sda_o(sda_o_l), .sda_oe(sda_oe_l),
      .acc_mem(acc_mem_l), .acc_addr(acc_addr_l), .acc_rd(acc_rd_l),
      .acc_wr(), .acc_wdata(), .acc_rdata(acc_rdata_l));

   // large variant store: only reads reach it in this bench
   always @(posedge clk) begin
      if (acc_rd_l) acc_rdata_l <= acc_mem_l ? fm_mem[acc_addr_l] : 8'h00;
   end

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // link clock unrelated in phase to the system clock
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #6 link_clk = ~link_clk;
   end

   // user store: data valid the cycle after the read strobe
   always @(posedge clk) begin
      if (acc_rd) acc_rdata <= acc_mem ? fm_mem[acc_addr]
                                       : rtc_mem[acc_addr[7:0]];
      if (acc_wr && acc_mem) fm_mem[acc_addr] <= acc_wdata;
      if (acc_wr && !acc_mem) rtc_mem[acc_addr[7:0]] <= acc_wdata;
   end

   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string msg);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s seen %h expected %h",
                  $time, msg, seen, exp);
      end
   endtask

   function automatic logic [7:0] exp_byte(input logic sel,
                                           input logic [12:0] p);
      return sel ? fm_mem[p] : rtc_mem[p[7:0]];
   endfunction

   // clock set wraps past its last location, memory past 7ff
   function automatic logic [12:0] next_ptr(input logic sel,
                                            input logic [12:0] p);
      if (sel) return (p + 13'h0001) & i2c_rp_pkg::MEM_SMALL_MASK;
      if (p[7:0] == i2c_rp_pkg::RTC_LAST) return 13'h0000;
      return p + 13'h0001;
   endfunction

   function automatic logic [6:0] slave_of(input logic sel,
                                           input logic [2:0] blk);
      return sel ? {i2c_rp_pkg::MEM_SMALL_TOP, blk}
                 : i2c_rp_pkg::RTC_SLAVE;
   endfunction

   // address-only write to set the read start
   task automatic wr_ptr(input logic sel, input logic [12:0] p);
      logic a;
      u_master.start_cond();
      u_master.send_byte({slave_of(sel, p[10:8]), 1'b0}, a);
      check({7'h00, a}, 8'h00, "write address ack");
      u_master.send_byte(p[7:0], a);
      check({7'h00, a}, 8'h00, "pointer byte ack");
      u_master.stop_cond();
      if (sel) mem_ptr = p;
      else rtc_ptr = p;
   endtask

   // read n bytes from the current pointer, not-ack on the last
   task automatic rd(input logic sel, input logic [2:0] blk, input int n);
      logic        a;
      logic [7:0]  d;
      logic [12:0] p;
      u_master.start_cond();
      u_master.send_byte({slave_of(sel, blk), 1'b1}, a);
      check({7'h00, a}, 8'h00, "read address ack");
      p = sel ? mem_ptr : rtc_ptr;
      for (int i = 0; i < n; i++) begin
         u_master.recv_byte(i == n - 1, d);
         check(d, exp_byte(sel, p), "read byte");
         p = next_ptr(sel, p);
      end
      #70;
      check({7'h00, sda_oe}, 8'h00, "data line released");
      u_master.stop_cond();
      if (sel) mem_ptr = p;
      else rtc_ptr = p;
   endtask

   // large variant: two pointer bytes, then a read of n bytes from that pointer
   task automatic rd_large(input logic [12:0] p, input int n);
      logic       a;
      logic [7:0] d;
      u_master_l.start_cond();
      u_master_l.send_byte({i2c_rp_pkg::MEM_LARGE_SLAVE, 1'b0}, a);
      check({7'h00, a}, 8'h00, "large address ack");
      u_master_l.send_byte({3'h0, p[12:8]}, a);
      u_master_l.send_byte(p[7:0], a);
      check({7'h00, a}, 8'h00, "large pointer ack");
      u_master_l.stop_cond();
      u_master_l.start_cond();
      u_master_l.send_byte({i2c_rp_pkg::MEM_LARGE_SLAVE, 1'b1}, a);
      check({7'h00, a}, 8'h00, "large read ack");
      for (int i = 0; i < n; i++) begin
         u_master_l.recv_byte(i == n - 1, d);
         check(d, fm_mem[p], "large read byte");
         p = (p + 13'h0001) & i2c_rp_pkg::MEM_LARGE_MASK;
      end
      u_master_l.stop_cond();
   endtask

   initial begin
      logic        a, sel;
      logic [7:0]  q, d;
      logic [12:0] p;
      int          n;
      rst = 1'b1;
      acc_rdata = 8'h00;
      acc_rdata_l = 8'h00;
      bad_count = 0;
      comparisons = 0;
      cycles = 0;
      rtc_ptr = 13'h0000;
      mem_ptr = 13'h0000;
      for (int i = 0; i < 256; i++) rtc_mem[i] = 8'($random(seed));
      for (int i = 0; i < 8192; i++) fm_mem[i] = 8'($random(seed));
      repeat (5) @(posedge clk);
      check({6'h00, sda_oe, acc_rd}, 8'h00, "idle in reset");
      rst <= 1'b0;
      repeat (20) @(posedge clk);
      rd(1'b0, 3'h0, 2);
      $display("test reset pointer done");
      wr_ptr(1'b0, 13'h00fe);
      rd(1'b0, 3'h0, 4);
      rd(1'b0, 3'h0, 2);
      $display("test clock wrap and keep done");
      wr_ptr(1'b1, 13'h07fe);
      rd(1'b1, 3'h7, 3);
      $display("test memory wrap done");
      // pointer then one data byte, then read the next location
      q = 8'($random(seed));
      d = 8'($random(seed));
      u_master.start_cond();
      u_master.send_byte({i2c_rp_pkg::RTC_SLAVE, 1'b0}, a);
      u_master.send_byte(q, a);
      u_master.send_byte(d, a);
      check({7'h00, a}, 8'h00, "data byte ack");
      u_master.stop_cond();
      check(rtc_mem[q], d, "stored byte");
      rtc_ptr = next_ptr(1'b0, {5'h00, q});
      rd(1'b0, 3'h0, 1);
      $display("test write then read done");
      u_master.start_cond();
      u_master.send_byte({7'h3c, 1'b1}, a);
      check({7'h00, a}, 8'h01, "foreign address ignored");
      u_master.stop_cond();
      rd(1'b0, 3'h0, 1);
      $display("test foreign address done");
      rd_large(13'h1ffe, 3);
      rd_large(13'($random(seed)), 2);
      $display("test large variant done");
      for (int k = 0; k < 8; k++) begin
         sel = 1'($random(seed));
         p = 13'($random(seed));
         n = 1 + ({$random(seed)} % 4);
         if (sel) p[12:11] = 2'h0;
         else p[12:8] = 5'h00;
         wr_ptr(sel, p);
         rd(sel, p[10:8], n);
      end
      $display("test random reads done");
      finish_test();
   end
endmodule
`default_nettype wire
